// [bench/sps_motor_model.sv]
`timescale 1ns/1ps
// Motor behind the output stage: current follows load, speed follows ramp commands
module sps_motor_model (
   input wire logic ref_clk,
   input wire logic set_en,
   input wire logic [15:0] set_freq,
   input wire logic [15:0] load,
   input wire logic force_decel,
   input wire logic hold_decel,
   output logic [15:0] out_current,
   output logic [15:0] out_freq
);
   // Current lags one cycle; forced decel never takes speed under the 1 Hz floor, though set_en loads set_freq unchecked
   always_ff @(posedge ref_clk) begin
      out_current <= load;
      if (set_en) begin
         out_freq <= set_freq;
      end else if (force_decel && out_freq > 16'h000a) begin
         out_freq <= out_freq - 16'h0001;
      end else if (hold_decel && out_freq < 16'h0fa0) begin
         out_freq <= out_freq + 16'h0001;
      end
   end
endmodule

// [bench/stall_prevention_supervisor_tb.sv]
`timescale 1ns/1ps
module stall_prevention_supervisor_tb;
   logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, accel, decel;
   logic regen_avoid_active, ov_stall_active, set_en, err, irq, clk_en;
   logic ramp_hold_accel, ramp_force_decel, ramp_hold_decel, out_shutoff;
   logic stall_overload_fault, stall_active_flag;
   logic [1:0] out_terms;
   logic [4:0] in_terms;
   logic [7:0] paddr;
   logic [15:0] out_current, out_freq, set_freq, load;
   logic [31:0] pwdata, prdata, rd;
   logic [31:0] rst_tab [6] = '{32'h5dc, 32'h270f, 32'h270f, 32'h258, 32'h0, 32'h0};
   logic [2:0] ramp_tab [3] = '{3'b110, 3'b010, 3'b001};
   wire logic [2:0] ramps = {ramp_hold_accel, ramp_force_decel, ramp_hold_decel};
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;

   sps_top #(.CTRL_CYCLES(2), .HOLD_TICKS(5), .DLY_UNIT_TICKS(3), .TRIP_TICKS(10))
      i_sps_top (.*);
   sps_motor_model i_sps_motor_model (.ref_clk(ref_clk), .set_en(set_en),
      .set_freq(set_freq), .load(load), .force_decel(ramp_force_decel),
      .hold_decel(ramp_hold_decel), .out_current(out_current), .out_freq(out_freq));

   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
   endtask

   task automatic reset_dut();
      sys_rst <= 1'b1;
      tick(4);
      sys_rst <= 1'b0;
      tick(1);
   endtask

   task automatic set_speed(input logic [15:0] f);
      set_en <= 1'b1;
      set_freq <= f;
      tick(1);
      set_en <= 1'b0;
      tick(2);
   endtask

   // Main sequence
   initial begin
      {psel, penable, pwrite, accel, decel, regen_avoid_active, ov_stall_active} = '0;
      paddr = '0;
      pwdata = '0;
      in_terms = '0;
      clk_en = 1'b1;
      load = '0;
      set_en = 1'b1;
      set_freq = 16'h01f4;
      sys_rst = 1'b1;
      tick(4);
      sys_rst <= 1'b0;
      set_en <= 1'b0;
      tick(1);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reset value", rst_tab[i], rd);
      end
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'b1, 8'h10, 32'h20);
      chk("select 32 error", 32'h1, {31'h0, err});
      apb(1'b1, 8'h10, 32'h65);
      chk("select 101 error", 32'h0, {31'h0, err});
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h18, 32'h6703);
      apb(1'b1, 8'h28, 32'h7);
      // Flag on with no delay, held, then released
      load <= 16'h0640;
      tick(5);
      chk("flag on", 32'h1, {31'h0, stall_active_flag});
      chk("terminals on", 32'h1, {30'h0, out_terms});
      chk("irq raised", 32'h1, {31'h0, irq});
      load <= 16'h0578;
      tick(5);
      chk("flag held", 32'h1, {31'h0, stall_active_flag});
      for (n = 0; n < 40 && stall_active_flag !== 1'b0; n++) @(posedge ref_clk);
      tick(1);
      chk("terminals off", 32'h2, {30'h0, out_terms});
      apb(1'b1, 8'h28, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, 8'h28, 32'h7);
      apb(1'b1, 8'h24, 32'h7);
      apb(1'b0, 8'h24, 32'h0);
      chk("irq status cleared", 32'h0, rd);
      // Ramp action in each phase
      load <= 16'h0640;
      for (int p = 0; p < 3; p++) begin
         accel <= (p == 0);
         decel <= (p == 2);
         tick(3);
         chk("ramp phase", 32'(ramp_tab[p]), 32'(ramps));
      end
      decel <= 1'b0;
      accel <= 1'b1;
      apb(1'b1, 8'h10, 32'h2);
      chk("accel disabled", 32'h0, 32'(ramps));
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      chk("primary zero", 32'h0, 32'(ramps));
      apb(1'b1, 8'h00, 32'h5dc);
      // Second threshold through terminal 0 only
      accel <= 1'b0;
      load <= 16'h04b0;
      apb(1'b1, 8'h1c, 32'h3);
      apb(1'b1, 8'h08, 32'h3e8);
      in_terms <= 5'h02;
      tick(3);
      chk("other terminal", 32'h0, 32'(ramps));
      in_terms <= 5'h01;
      tick(3);
      chk("second level", 32'h2, 32'(ramps));
      apb(1'b1, 8'h08, 32'h270f);
      tick(1);
      chk("second copies", 32'h0, 32'(ramps));
      // Flag delay settings and other sources, starting from a dropped flag
      load <= 16'h0;
      for (n = 0; n < 40 && stall_active_flag !== 1'b0; n++) @(posedge ref_clk);
      apb(1'b1, 8'h14, 32'h270f);
      regen_avoid_active <= 1'b1;
      tick(20);
      chk("no flag", 32'h0, {31'h0, stall_active_flag});
      regen_avoid_active <= 1'b0;
      apb(1'b1, 8'h14, 32'h1);
      ov_stall_active <= 1'b1;
      tick(3);
      chk("flag delayed", 32'h0, {31'h0, stall_active_flag});
      // Clock enable low freezes the delay count
      clk_en <= 1'b0;
      tick(10);
      chk("frozen delay", 32'h0, {31'h0, stall_active_flag});
      clk_en <= 1'b1;
      for (n = 0; n < 40 && stall_active_flag !== 1'b1; n++) @(posedge ref_clk);
      chk("flag late", 32'h1, {31'h0, stall_active_flag});
      ov_stall_active <= 1'b0;
      apb(1'b1, 8'h14, 32'h0);
      // Reduced level at 120 Hz
      set_speed(16'h04b0);
      apb(1'b0, 8'h20, 32'h0);
      chk("level constant", 32'h5dc, {16'h0, rd[15:0]});
      apb(1'b1, 8'h04, 32'h3e8);
      apb(1'b0, 8'h20, 32'h0);
      chk("level reduced", 32'h2ee, {16'h0, rd[15:0]});
      apb(1'b1, 8'h04, 32'h270f);
      // Pinned at the floor trips
      set_speed(16'h000a);
      load <= 16'h0640;
      for (n = 0; n < 80 && stall_overload_fault !== 1'b1; n++) @(posedge ref_clk);
      chk("floor fault", 32'h3, {30'h0, stall_overload_fault, out_shutoff});
      load <= 16'h0;
      apb(1'b1, 8'h2c, 32'h1);
      chk("fault cleared", 32'h0, {31'h0, stall_overload_fault});
      // Fast current limit, then with it disabled
      load <= 16'h08fc;
      tick(3);
      chk("fast shutoff", 32'h1, {31'h0, out_shutoff});
      load <= 16'h0;
      // Select 16 trips as soon as the flag is shown, well before the floor timer
      apb(1'b1, 8'h10, 32'h10);
      load <= 16'h0640;
      tick(8);
      chk("stop on flag", 32'h1, {31'h0, stall_overload_fault});
      load <= 16'h0;
      reset_dut();
      apb(1'b1, 8'h10, 32'h65);
      load <= 16'h08fc;
      tick(3);
      chk("fast disabled", 32'h0, {31'h0, out_shutoff});
      results();
   end
endmodule

// [core/sps_pkg.sv]
package sps_pkg;
   // Clock and control cycle timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CTRL_PERIOD_NS = 1000;
   localparam int unsigned CTRL_CYCLES = (CTRL_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned FLAG_HOLD_MS = 100;
   localparam int unsigned FLAG_HOLD_TICKS = FLAG_HOLD_MS * (1_000_000 / CTRL_PERIOD_NS);
   localparam int unsigned DLY_UNIT_MS = 100;
   localparam int unsigned DLY_UNIT_TICKS = DLY_UNIT_MS * (1_000_000 / CTRL_PERIOD_NS);
   localparam int unsigned TRIP_S = 3;
   localparam int unsigned TRIP_TICKS = TRIP_S * (1_000_000_000 / CTRL_PERIOD_NS);
   // Register offsets
   localparam logic [7:0] OFS_THR1 = 8'h00;
   localparam logic [7:0] OFS_COMP = 8'h04;
   localparam logic [7:0] OFS_THR2 = 8'h08;
   localparam logic [7:0] OFS_RSF = 8'h0c;
   localparam logic [7:0] OFS_SEL = 8'h10;
   localparam logic [7:0] OFS_FDLY = 8'h14;
   localparam logic [7:0] OFS_OUTFN = 8'h18;
   localparam logic [7:0] OFS_INFN = 8'h1c;
   localparam logic [7:0] OFS_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ = 8'h24;
   localparam logic [7:0] OFS_MASK = 8'h28;
   localparam logic [7:0] OFS_FCLR = 8'h2c;
   // Reset values and setting codes
   localparam logic [15:0] THR1_RST = 16'h05dc;
   localparam logic [15:0] CODE_OFF = 16'h270f;
   localparam logic [15:0] RSF_RST = 16'h0258;
   localparam logic [15:0] THR_MAX = 16'h07d0;
   localparam logic [15:0] FREQ_MAX = 16'h0fa0;
   localparam logic [15:0] FREQ_FLOOR = 16'h000a;
   localparam logic [15:0] COMP_UNIT = 16'h03e8;
   localparam logic [15:0] FDLY_MAX = 16'h00fa;
   localparam logic [15:0] FAST_LIMIT_RST = 16'h0898;
   localparam logic [7:0] SEL_ALL = 8'h64;
   localparam logic [7:0] SEL_NOFAST = 8'h65;
   localparam logic [7:0] SEL_MAX = 8'h1f;
   localparam logic [7:0] FN_FLAG = 8'h03;
   localparam logic [7:0] FN_FLAG_N = 8'h67;
   localparam logic [5:0] FN_SECOND = 6'h03;
   // Select field positions
   localparam int SEL_NOFAST_B = 0;
   localparam int SEL_NOACC_B = 1;
   localparam int SEL_NOCON_B = 2;
   localparam int SEL_NODEC_B = 3;
   localparam int SEL_STOP_B = 4;
   // Interrupt bit positions
   localparam int IRQ_FLAG_B = 0;
   localparam int IRQ_FAULT_B = 1;
   localparam int IRQ_FAST_B = 2;
   localparam int IRQ_W = 3;
   localparam int N_IN_TERMS = 5;

   typedef enum logic [1:0] {
      SPS_IDLE = 2'b00,
      SPS_WAIT = 2'b01,
      SPS_ON = 2'b10
   } sps_flag_type;
endpackage

// [core/sps_thr.sv]
`timescale 1ns/1ps
// High frequency threshold reduction, registered result
module sps_thr (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   sps_thr_if.calc t
);
   logic [31:0] fl;
   logic [31:0] a;
   logic [31:0] b;
   logic signed [47:0] s_a;
   logic signed [47:0] s_b;
   logic signed [47:0] s_l;
   logic signed [47:0] s_c;
   logic signed [47:0] num;
   logic signed [47:0] den;
   logic signed [47:0] lvl;
   logic above;

   // Reduction applies only above the start frequency with a factor set
   assign above = (t.comp != sps_pkg::CODE_OFF) && (t.out_freq > t.start_freq)
      && (t.start_freq < sps_pkg::FREQ_MAX) && (t.base_lvl != 16'h0000);
   assign fl = t.start_freq * t.base_lvl;
   assign a = (t.out_freq == 16'h0000) ? 32'h0 : fl / 32'(t.out_freq);
   assign b = fl / 32'(sps_pkg::FREQ_MAX);
   assign s_a = signed'(48'(a));
   assign s_b = signed'(48'(b));
   assign s_l = signed'(48'(t.base_lvl));
   assign s_c = signed'(48'(t.comp)) - signed'(48'(sps_pkg::COMP_UNIT));
   // A + B*(L-A)/(L-B)*(C-1000)/1000, all in 0.1 percent units
   assign num = s_b * (s_l - s_a) * s_c;
   assign den = (s_l - s_b) * signed'(48'(sps_pkg::COMP_UNIT));
   assign lvl = (den == 48'sh0) ? s_l : s_a + num / den;

   // Result register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         t.eff_lvl <= sps_pkg::THR1_RST;
      end else if (clk_en) begin
         if (!above) begin
            t.eff_lvl <= t.base_lvl;
         end else if (lvl < 48'sh0) begin
            t.eff_lvl <= 16'h0000;
         end else begin
            t.eff_lvl <= lvl[15:0];
         end
      end
   end
endmodule

// [core/sps_thr_if.sv]
`timescale 1ns/1ps
// Carries the threshold settings to the reduction calculator
interface sps_thr_if;
   logic [15:0] base_lvl;
   logic [15:0] comp;
   logic [15:0] start_freq;
   logic [15:0] out_freq;
   logic [15:0] eff_lvl;
   modport calc (input base_lvl, input comp, input start_freq, input out_freq,
      output eff_lvl);
   modport user (output base_lvl, output comp, output start_freq, output out_freq,
      input eff_lvl);
endinterface

// [core/sps_top.sv]
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Stall prevention supervisor with APB settings
module sps_top #(
   parameter int unsigned CTRL_CYCLES = sps_pkg::CTRL_CYCLES,
   parameter int unsigned HOLD_TICKS = sps_pkg::FLAG_HOLD_TICKS,
   parameter int unsigned DLY_UNIT_TICKS = sps_pkg::DLY_UNIT_TICKS,
   parameter int unsigned TRIP_TICKS = sps_pkg::TRIP_TICKS,
   parameter logic [15:0] FAST_LIMIT = sps_pkg::FAST_LIMIT_RST
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] out_current,
   input wire logic [15:0] out_freq,
   input wire logic accel,
   input wire logic decel,
   input wire logic regen_avoid_active,
   input wire logic ov_stall_active,
   input wire logic [sps_pkg::N_IN_TERMS-1:0] in_terms,
   output logic ramp_hold_accel,
   output logic ramp_force_decel,
   output logic ramp_hold_decel,
   output logic out_shutoff,
   output logic stall_overload_fault,
   output logic stall_active_flag,
   output logic [1:0] out_terms,
   output logic irq
);
   // Setting registers
   logic [15:0] stall_threshold_primary;
   logic [15:0] double_speed_comp_factor;
   logic [15:0] stall_threshold_second;
   logic [15:0] reduction_start_freq;
   logic [7:0] stall_operation_select;
   logic [15:0] stall_flag_delay;
   logic [7:0] output_terminal_function_a;
   logic [7:0] output_terminal_function_b;
   logic [29:0] input_terminal_functions;
   logic [sps_pkg::IRQ_W-1:0] irq_stat;
   logic [sps_pkg::IRQ_W-1:0] irq_mask;
   // Working state
   sps_pkg::sps_flag_type flag_st;
   sps_pkg::sps_flag_type next_flag_st;
   logic [15:0] tick_div;
   logic [31:0] flag_cnt;
   logic [31:0] trip_cnt;
   logic fast_trip;
   logic prev_flag;
   logic prev_fault;

   sps_thr_if thr ();

   sps_thr u_thr (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .t(thr.calc)
   );

   // APB decode and write value checks
   logic wr_en;
   logic addr_ok;
   logic val_ok;
   logic [15:0] wv;
   assign wv = pwdata[15:0];
   assign pready = clk_en;
   assign wr_en = psel && penable && pwrite && clk_en && !pslverr;
   assign addr_ok = (paddr <= sps_pkg::OFS_FCLR) && (paddr[1:0] == 2'b00);
   always_comb begin
      unique case (paddr)
         sps_pkg::OFS_THR1: val_ok = wv <= sps_pkg::THR_MAX;
         sps_pkg::OFS_COMP: val_ok = wv <= sps_pkg::THR_MAX || wv == sps_pkg::CODE_OFF;
         sps_pkg::OFS_THR2: val_ok = wv <= sps_pkg::THR_MAX || wv == sps_pkg::CODE_OFF;
         sps_pkg::OFS_RSF: val_ok = wv <= sps_pkg::FREQ_MAX;
         sps_pkg::OFS_SEL: val_ok = pwdata[7:0] <= sps_pkg::SEL_MAX
            || pwdata[7:0] == sps_pkg::SEL_ALL || pwdata[7:0] == sps_pkg::SEL_NOFAST;
         sps_pkg::OFS_FDLY: val_ok = wv <= sps_pkg::FDLY_MAX || wv == sps_pkg::CODE_OFF;
         default: val_ok = 1'b1;
      endcase
   end
   assign pslverr = psel && penable && (!addr_ok || (pwrite && !val_ok));

   // Read mux
   logic [31:0] stat_word;
   assign stat_word = {8'h00, 1'b0, fast_trip, stall_overload_fault, stall_active_flag,
      4'h0, thr.eff_lvl};
   always_comb begin
      unique case (paddr)
         sps_pkg::OFS_THR1: prdata = {16'h0000, stall_threshold_primary};
         sps_pkg::OFS_COMP: prdata = {16'h0000, double_speed_comp_factor};
         sps_pkg::OFS_THR2: prdata = {16'h0000, stall_threshold_second};
         sps_pkg::OFS_RSF: prdata = {16'h0000, reduction_start_freq};
         sps_pkg::OFS_SEL: prdata = {24'h000000, stall_operation_select};
         sps_pkg::OFS_FDLY: prdata = {16'h0000, stall_flag_delay};
         sps_pkg::OFS_OUTFN: prdata = {16'h0000, output_terminal_function_b,
            output_terminal_function_a};
         sps_pkg::OFS_INFN: prdata = {2'b00, input_terminal_functions};
         sps_pkg::OFS_STAT: prdata = stat_word;
         sps_pkg::OFS_IRQ: prdata = {29'h0, irq_stat};
         sps_pkg::OFS_MASK: prdata = {29'h0, irq_mask};
         default: prdata = 32'h00000000;
      endcase
   end

   // Setting register writes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stall_threshold_primary <= sps_pkg::THR1_RST;
         double_speed_comp_factor <= sps_pkg::CODE_OFF;
         stall_threshold_second <= sps_pkg::CODE_OFF;
         reduction_start_freq <= sps_pkg::RSF_RST;
         stall_operation_select <= 8'h00;
         stall_flag_delay <= 16'h0000;
         output_terminal_function_a <= 8'h00;
         output_terminal_function_b <= 8'h00;
         input_terminal_functions <= 30'h0;
         irq_mask <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            sps_pkg::OFS_THR1: stall_threshold_primary <= wv;
            sps_pkg::OFS_COMP: double_speed_comp_factor <= wv;
            sps_pkg::OFS_THR2: stall_threshold_second <= wv;
            sps_pkg::OFS_RSF: reduction_start_freq <= wv;
            sps_pkg::OFS_SEL: stall_operation_select <= pwdata[7:0];
            sps_pkg::OFS_FDLY: stall_flag_delay <= wv;
            sps_pkg::OFS_OUTFN: {output_terminal_function_b, output_terminal_function_a}
               <= wv;
            sps_pkg::OFS_INFN: input_terminal_functions <= pwdata[29:0];
            sps_pkg::OFS_MASK: irq_mask <= pwdata[sps_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Second set input from terminals coded for it
   logic second_sel;
   logic [sps_pkg::N_IN_TERMS-1:0] sec_hit;
   genvar gi;
   for (gi = 0; gi < sps_pkg::N_IN_TERMS; gi++) begin : g_in
      assign sec_hit[gi] = in_terms[gi]
         && input_terminal_functions[gi*6 +: 6] == sps_pkg::FN_SECOND;
   end
   assign second_sel = |sec_hit;

   // Threshold selection feeds the reduction calculator
   logic [15:0] base_lvl;
   assign base_lvl = (second_sel && stall_threshold_second != sps_pkg::CODE_OFF)
      ? stall_threshold_second : stall_threshold_primary;
   assign thr.base_lvl = base_lvl;
   assign thr.comp = double_speed_comp_factor;
   assign thr.start_freq = reduction_start_freq;
   assign thr.out_freq = out_freq;

   // Phase gating from the operation select
   logic all_on;
   logic fast_en;
   logic phase_en;
   logic stop_on_flag;
   logic over;
   logic stall_act;
   logic flag_src;
   assign all_on = stall_operation_select[7]
      || stall_operation_select == sps_pkg::SEL_ALL;
   assign fast_en = stall_operation_select == sps_pkg::SEL_ALL
      || (stall_operation_select <= sps_pkg::SEL_MAX
      && !stall_operation_select[sps_pkg::SEL_NOFAST_B]);
   assign phase_en = all_on || stall_operation_select == sps_pkg::SEL_NOFAST
      || (accel ? !stall_operation_select[sps_pkg::SEL_NOACC_B]
      : decel ? !stall_operation_select[sps_pkg::SEL_NODEC_B]
      : !stall_operation_select[sps_pkg::SEL_NOCON_B]);
   assign stop_on_flag = stall_operation_select <= sps_pkg::SEL_MAX
      && stall_operation_select[sps_pkg::SEL_STOP_B];
   assign over = base_lvl != 16'h0000 && out_current > thr.eff_lvl;
   assign stall_act = over && phase_en && !out_shutoff;
   assign flag_src = stall_act || regen_avoid_active || ov_stall_active;

   // Ramp steering while stall prevention acts
   assign ramp_hold_accel = stall_act && accel;
   assign ramp_force_decel = stall_act && (accel || !decel);
   assign ramp_hold_decel = stall_act && decel && !accel;

   // Control cycle tick
   logic tick;
   assign tick = tick_div == 16'(CTRL_CYCLES - 1);
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tick_div <= 16'h0000;
      end else if (clk_en) begin
         tick_div <= tick ? 16'h0000 : tick_div + 16'h0001;
      end
   end

   // Flag delay and minimum on time
   logic [31:0] dly_ticks;
   logic dly_done;
   logic hold_done;
   assign dly_ticks = 32'(stall_flag_delay) * DLY_UNIT_TICKS;
   assign dly_done = flag_cnt + 32'h1 >= dly_ticks;
   assign hold_done = flag_cnt > HOLD_TICKS;
   always_comb begin
      next_flag_st = flag_st;
      unique case (flag_st)
         sps_pkg::SPS_IDLE: begin
            if (flag_src && stall_flag_delay != sps_pkg::CODE_OFF) begin
               next_flag_st = (stall_flag_delay == 16'h0000)
                  ? sps_pkg::SPS_ON : sps_pkg::SPS_WAIT;
            end
         end
         sps_pkg::SPS_WAIT: begin
            if (!flag_src || stall_flag_delay == sps_pkg::CODE_OFF) begin
               next_flag_st = sps_pkg::SPS_IDLE;
            end else if (dly_done) begin
               next_flag_st = sps_pkg::SPS_ON;
            end
         end
         sps_pkg::SPS_ON: begin
            if (hold_done && !flag_src) begin
               next_flag_st = sps_pkg::SPS_IDLE;
            end
         end
         default: next_flag_st = sps_pkg::SPS_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flag_st <= sps_pkg::SPS_IDLE;
         flag_cnt <= 32'h0;
      end else if (clk_en && tick) begin
         flag_st <= next_flag_st;
         flag_cnt <= (next_flag_st != flag_st) ? 32'h0
            : ((hold_done && flag_st != sps_pkg::SPS_WAIT) ? flag_cnt : flag_cnt + 32'h1);
      end
   end
   assign stall_active_flag = flag_st == sps_pkg::SPS_ON;

   // Output terminal mapping
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         out_terms <= 2'b00;
      end else if (clk_en) begin
         out_terms[0] <= (output_terminal_function_a == sps_pkg::FN_FLAG && stall_active_flag)
            || (output_terminal_function_a == sps_pkg::FN_FLAG_N && !stall_active_flag);
         out_terms[1] <= (output_terminal_function_b == sps_pkg::FN_FLAG && stall_active_flag)
            || (output_terminal_function_b == sps_pkg::FN_FLAG_N && !stall_active_flag);
      end
   end

   // Floor timer, stall overload fault and fast limit trip
   logic floor_stall;
   logic fault_clr;
   logic fast_hit;
   assign floor_stall = stall_act && out_freq <= sps_pkg::FREQ_FLOOR;
   assign fault_clr = wr_en && paddr == sps_pkg::OFS_FCLR && pwdata[0];
   assign fast_hit = fast_en && out_current > FAST_LIMIT;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         trip_cnt <= 32'h0;
         stall_overload_fault <= 1'b0;
         fast_trip <= 1'b0;
      end else if (clk_en) begin
         if (tick) begin
            trip_cnt <= floor_stall ? trip_cnt + 32'h1 : 32'h0;
         end
         if ((tick && floor_stall && trip_cnt + 32'h1 >= TRIP_TICKS)
            || (stop_on_flag && stall_active_flag)) begin
            stall_overload_fault <= 1'b1;
         end else if (fault_clr) begin
            stall_overload_fault <= 1'b0;
         end
         fast_trip <= fast_hit;
      end
   end
   assign out_shutoff = fast_hit || fast_trip || stall_overload_fault;

   // Sticky interrupt status, set wins over clear
   logic [sps_pkg::IRQ_W-1:0] ev;
   logic [sps_pkg::IRQ_W-1:0] clr;
   assign ev = {fast_hit, stall_overload_fault && !prev_fault, stall_active_flag && !prev_flag};
   assign clr = (wr_en && paddr == sps_pkg::OFS_IRQ) ? pwdata[sps_pkg::IRQ_W-1:0] : '0;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_stat <= '0;
         prev_flag <= 1'b0;
         prev_fault <= 1'b0;
      end else if (clk_en) begin
         irq_stat <= (irq_stat & ~clr) | ev;
         prev_flag <= stall_active_flag;
         prev_fault <= stall_overload_fault;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // Checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   property p_ramp;
      stall_act |-> (accel ? (ramp_hold_accel && ramp_force_decel)
         : decel ? (ramp_hold_decel && !ramp_force_decel) : ramp_force_decel);
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp steering wrong");

   property p_fast;
      (clk_en && fast_en && out_current > FAST_LIMIT) |=> fast_trip && out_shutoff;
   endproperty
   a_fast: assert property (p_fast) else $error("fast limit not shut off");

   property p_hold;
      $fell(stall_active_flag) |-> $past(flag_cnt) > HOLD_TICKS;
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped too early");

   property p_never;
      (stall_flag_delay == sps_pkg::CODE_OFF && !stall_active_flag) |=> !stall_active_flag;
   endproperty
   a_never: assert property (p_never) else $error("flag shown while suppressed");

   property p_imm;
      (clk_en && tick && flag_st == sps_pkg::SPS_IDLE && flag_src
         && stall_flag_delay == 16'h0000) |=> stall_active_flag;
   endproperty
   a_imm: assert property (p_imm) else $error("flag not immediate");

   property p_term;
      (clk_en && output_terminal_function_a == sps_pkg::FN_FLAG_N)
         |=> out_terms[0] == !$past(stall_active_flag);
   endproperty
   a_term: assert property (p_term) else $error("inverted terminal wrong");

   property p_trip;
      (clk_en && tick && floor_stall && trip_cnt + 32'h1 >= TRIP_TICKS)
         |=> stall_overload_fault && out_shutoff;
   endproperty
   a_trip: assert property (p_trip) else $error("floor trip missing");

   property p_zero;
      base_lvl == 16'h0000 |-> !(ramp_hold_accel || ramp_force_decel || ramp_hold_decel);
   endproperty
   a_zero: assert property (p_zero) else $error("stall acts while disabled");

   property p_sec;
      (second_sel && stall_threshold_second != sps_pkg::CODE_OFF)
         |-> thr.base_lvl == stall_threshold_second;
   endproperty
   a_sec: assert property (p_sec) else $error("second level not used");
endmodule
